// >>> rtl/agcl_pkg.sv
`default_nettype none
package agcl_pkg;
   localparam int CFG_W = 32;
   localparam int DIS_BIT = 31;
   localparam int EXP_LSB = 28;
   localparam int EXP_W = 3;
   localparam int MANT_LSB = 24;
   localparam int MANT_W = 4;
   localparam int THR_LSB = 16;
   localparam int THR_W = 8;
   localparam int UPPER_LSB = 8;
   localparam int LOWER_LSB = 0;
   localparam int LIM_W = 8;
   localparam int MAG_W = 8;
   localparam int ERR_W = 9;
   localparam int PROD_W = 14;
   localparam int ACC_W = 20;
   localparam int FRAC_W = 12;
   localparam int SUM_W = 22;
   localparam int GAIN_W = 8;
   localparam int GMANT_W = 6;
   localparam int LIN_W = 10;
   localparam logic [CFG_W-1:0] CFG_RESET = 32'h0000_ff00;
   localparam logic [ACC_W-1:0] ACC_RESET = 20'h00000;
   localparam logic [LIN_W-1:0] LIN_RESET = 10'h040;
   localparam logic [GMANT_W:0] LIN_ONE = 7'h40;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
endpackage
`default_nettype wire

// >>> rtl/agcl_stream_if.sv
`default_nettype none
interface agcl_stream_if;
   logic valid;
   logic ready;
   logic [agcl_pkg::GAIN_W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> rtl/agcl_skid.sv
`default_nettype none
module agcl_skid (
   input wire logic clk, // System clock
   input wire logic resetn, // Async reset, active low
   input wire logic clk_en, // Freezes state while low
   agcl_stream_if.snk up, // Filling side
   agcl_stream_if.src dn // Draining side
);
   typedef struct packed {
      logic [1:0][agcl_pkg::GAIN_W-1:0] mem;
      logic wr;
      logic rd;
      logic [1:0] cnt;
   } agcl_buf_t;

   agcl_buf_t st;
   agcl_buf_t next_st;
   logic push;
   logic pop;

   // Handshakes are masked while frozen so no word is taken or dropped
   assign up.ready = clk_en && (st.cnt != agcl_pkg::BUF_DEPTH);
   assign dn.valid = clk_en && (st.cnt != 2'h0);
   assign dn.data = st.mem[st.rd];
   assign push = up.valid && up.ready;
   assign pop = dn.valid && dn.ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = up.data;
         next_st.wr = ~st.wr;
      end
      if (pop) begin
         next_st.rd = ~st.rd;
      end
      next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   a_buf_never_over: assert property (st.cnt <= agcl_pkg::BUF_DEPTH)
      else $error("buffer count above depth");
   a_buf_keeps_order: assert property (push && st.cnt == 2'h0 |=> dn.data == $past(up.data))
      else $error("first word not presented");
endmodule
`default_nettype wire

// >>> rtl/agcl_loop_filter.sv
// Operation
// - Error is magnitude sample minus programmed threshold, before scaling.
// - Threshold is unsigned 8 bits at config bits 16 to 23.
// - Disable bit 31 forces error to zero; clear lets error pass.
// - Error scaled by 4-bit mantissa times 0.0625.
// - Error further shifted right by 7 plus 3-bit exponent.
// - Mantissa and exponent taken from config bits 24 to 30.
// - Scaled error accumulated; result drives I and Q gain.
// - Accumulator limited between programmed upper and lower limits.
// - Top eight bits are 2-bit exponent, 6-bit mantissa; limits compared alike.
// - Input placed twelve bits below mantissa, LSB weighted 2^-18.
// - Upper and lower limits from config bits 0 to 15.
// - Linear gain is (1 + m/64) times 2^e.
// - Top eight accumulator bits readable by host.
// - Update step set by loop gain and capped by limits.
`default_nettype none
module agcl_loop_filter (
   input wire logic clk, // System clock, 50 MHz
   input wire logic resetn, // Async reset, active low
   input wire logic clk_en, // Freezes all state while low
   input wire logic cfg_wr, // Loop config write strobe
   input wire logic [31:0] cfg_wdata, // Loop config write data
   output logic [31:0] cfg_rdata, // Loop config readback
   output logic [7:0] gain_status, // Current gain word for the host
   input wire logic mag_valid, // Magnitude sample valid
   input wire logic [7:0] mag_data, // Magnitude sample, unsigned
   output logic mag_ready, // Magnitude sample taken
   output logic gain_valid, // Gain word valid
   input wire logic gain_ready, // Multiplier side accepts word
   output logic [7:0] gain_data, // Gain word, exp/mantissa
   output logic [9:0] gain_linear // Applied linear gain, 2^-6 units
);
   typedef struct packed {
      logic [agcl_pkg::CFG_W-1:0] cfg;
      logic [agcl_pkg::ACC_W-1:0] acc;
      logic [agcl_pkg::LIN_W-1:0] lin;
   } agcl_state_t;

   agcl_state_t st;
   agcl_state_t next_st;

   // Exp/mantissa word to linear multiplier value
   function automatic logic [agcl_pkg::LIN_W-1:0] lin_of(
      input logic [agcl_pkg::GAIN_W-1:0] w);
      logic [agcl_pkg::LIN_W-1:0] base;
      base = {3'h0, agcl_pkg::LIN_ONE + {1'b0, w[agcl_pkg::GMANT_W-1:0]}};
      lin_of = base << w[agcl_pkg::GAIN_W-1:agcl_pkg::GMANT_W];
   endfunction

   // Limit word widened to a full accumulator bound; fill sets the fraction
   function automatic logic signed [agcl_pkg::SUM_W-1:0] lim_bound(
      input logic [agcl_pkg::LIM_W-1:0] lim,
      input logic fill);
      lim_bound = $signed({2'b00, lim, {agcl_pkg::FRAC_W{fill}}});
   endfunction

   logic dis;
   logic [agcl_pkg::MANT_W-1:0] mant;
   logic [agcl_pkg::EXP_W-1:0] expo;
   logic [agcl_pkg::THR_W-1:0] thr;
   logic [agcl_pkg::LIM_W-1:0] upper;
   logic [agcl_pkg::LIM_W-1:0] lower;
   logic signed [agcl_pkg::ERR_W-1:0] err;
   logic signed [agcl_pkg::PROD_W-1:0] prod;
   logic signed [agcl_pkg::PROD_W-1:0] scaled;
   logic signed [agcl_pkg::SUM_W-1:0] sum;
   logic signed [agcl_pkg::SUM_W-1:0] hi;
   logic signed [agcl_pkg::SUM_W-1:0] lo;
   logic accept;

   agcl_stream_if in_s ();
   agcl_stream_if out_s ();

   agcl_skid u_skid (
      .clk (clk),
      .resetn (resetn),
      .clk_en (clk_en),
      .up (in_s.snk),
      .dn (out_s.src)
   );

   assign dis = st.cfg[agcl_pkg::DIS_BIT];
   assign mant = st.cfg[agcl_pkg::MANT_LSB +: agcl_pkg::MANT_W];
   assign expo = st.cfg[agcl_pkg::EXP_LSB +: agcl_pkg::EXP_W];
   assign thr = st.cfg[agcl_pkg::THR_LSB +: agcl_pkg::THR_W];
   assign upper = st.cfg[agcl_pkg::UPPER_LSB +: agcl_pkg::LIM_W];
   assign lower = st.cfg[agcl_pkg::LOWER_LSB +: agcl_pkg::LIM_W];

   // A sample is taken only when the gain buffer has room, so a stalled
   // multiplier side holds off the converter instead of losing updates
   assign accept = mag_valid && mag_ready;
   assign mag_ready = in_s.ready;
   assign in_s.valid = mag_valid;
   assign in_s.data = sum[agcl_pkg::ACC_W-1:agcl_pkg::FRAC_W];
   assign gain_valid = out_s.valid;
   assign out_s.ready = gain_ready;
   assign gain_data = out_s.data;

   assign cfg_rdata = st.cfg;
   assign gain_status = st.acc[agcl_pkg::ACC_W-1:agcl_pkg::FRAC_W];
   assign gain_linear = st.lin;

   always_comb begin
      next_st = st;
      err = $signed({1'b0, mag_data}) - $signed({1'b0, thr});
      if (dis) begin
         err = '0;
      end
      prod = err * $signed({1'b0, mant});
      // Product LSB sits at 2^-11; shifting 7+E lands it on acc LSB 2^-18
      // after the fixed 7 is absorbed into the placement of the input
      scaled = prod >>> expo;
      sum = $signed({2'b00, st.acc}) + agcl_pkg::SUM_W'(scaled);
      hi = lim_bound(upper, 1'b1);
      lo = lim_bound(lower, 1'b0);
      // Limits act on the whole word so a fixed gain (both equal) pins it
      if (sum > hi) begin
         sum = hi;
      end
      if (sum < lo) begin
         sum = lo;
      end
      if (accept) begin
         next_st.acc = sum[agcl_pkg::ACC_W-1:0];
         next_st.lin = lin_of(sum[agcl_pkg::ACC_W-1:agcl_pkg::FRAC_W]);
      end
      if (cfg_wr) begin
         next_st.cfg = cfg_wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st.cfg <= agcl_pkg::CFG_RESET;
         st.acc <= agcl_pkg::ACC_RESET;
         st.lin <= agcl_pkg::LIN_RESET;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   logic [7:0] top;
   logic in_lim;
   assign top = st.acc[agcl_pkg::ACC_W-1:agcl_pkg::FRAC_W];
   assign in_lim = (top >= lower) && (top <= upper);

   a_disable_holds_gain: assert property (
      accept && dis && in_lim && !cfg_wr |=> $stable(st.acc))
      else $error("gain moved while loop disabled");
   a_error_raises_gain: assert property (
      accept && !dis && mant == 4'hf && expo == 3'h0 && mag_data > thr
      && top < upper && !cfg_wr |=> st.acc > $past(st.acc))
      else $error("positive error did not raise gain");
   a_error_lowers_gain: assert property (
      accept && !dis && mant != 4'h0 && {1'b0, mag_data} + 9'h001 < {1'b0, thr}
      && expo == 3'h0 && top > lower && !cfg_wr |=> st.acc < $past(st.acc))
      else $error("negative error did not lower gain");
   a_zero_mantissa_holds: assert property (
      accept && mant == 4'h0 && in_lim && !cfg_wr |=> $stable(st.acc))
      else $error("zero loop gain changed gain");
   a_step_max_shift: assert property (
      accept && expo == 3'h7 && in_lim && !cfg_wr |=>
      $signed({2'b00, st.acc}) - $signed({2'b00, $past(st.acc)}) <= 22'sd29
      && $signed({2'b00, st.acc}) - $signed({2'b00, $past(st.acc)}) >= -22'sd30)
      else $error("step exceeds weight at largest shift");
   a_acc_under_upper: assert property (
      accept && !cfg_wr && lower <= upper |=> top <= upper)
      else $error("gain above upper limit");
   a_acc_over_lower: assert property (
      accept && !cfg_wr && lower <= upper |=> top >= lower)
      else $error("gain below lower limit");
   a_fixed_gain_pins: assert property (
      accept && upper == lower && !cfg_wr |=> top == $past(upper))
      else $error("equal limits did not fix gain");
   a_status_follows_word: assert property (
      accept |=> gain_status == $past(in_s.data))
      else $error("status differs from pushed gain word");
   a_linear_of_status: assert property (
      accept |=> gain_linear == (10'(7'h40 + {1'b0, top[5:0]}) << top[7:6]))
      else $error("linear gain mismatch");
   a_stall_holds_word: assert property (
      clk_en && gain_valid && !gain_ready |=> clk_en |-> gain_valid && $stable(gain_data))
      else $error("stalled gain word changed");

   // Config word and clock enable
   a_cfg_write_lands: assert property (
      clk_en && cfg_wr |=> cfg_rdata == $past(cfg_wdata))
      else $error("config write did not land");

   a_cfg_holds_idle: assert property (
      !(clk_en && cfg_wr) |=> $stable(cfg_rdata))
      else $error("config changed without a write");

   a_freeze_holds_state: assert property (
      !clk_en |=> $stable(st))
      else $error("state moved while frozen");

   a_freeze_masks_ready: assert property (
      !clk_en |-> !mag_ready && !gain_valid)
      else $error("handshake open while frozen");

   a_ready_when_empty: assert property (
      clk_en && !gain_valid |-> mag_ready)
      else $error("sample refused with empty buffer");

   a_full_keeps_valid: assert property (
      clk_en && !mag_ready |=> gain_valid || !clk_en)
      else $error("full buffer lost its words");

   // Error detector and loop gain scaling
   a_error_zero_disabled: assert property (
      dis |-> err == 9'sh000)
      else $error("error not zero while disabled");

   a_error_zero_at_thr: assert property (
      !dis && mag_data == thr |-> err == 9'sh000)
      else $error("error not zero at threshold");

   a_error_sign_above: assert property (
      !dis && mag_data > thr |-> err > 9'sh000)
      else $error("error not positive above threshold");

   a_error_sign_below: assert property (
      !dis && mag_data < thr |-> err < 9'sh000)
      else $error("error not negative below threshold");

   a_zero_mant_product: assert property (
      mant == 4'h0 |-> prod == 14'sh0000)
      else $error("zero mantissa left a product");

   a_unit_mant_product: assert property (
      mant == 4'h1 |-> prod == 14'(err))
      else $error("unit mantissa changed the error");

   a_product_sign: assert property (
      mant != 4'h0 && err > 9'sh000 |-> prod > 14'sh0000)
      else $error("scaled error lost its sign");

   a_shift_zero_keeps: assert property (
      expo == 3'h0 |-> scaled == prod)
      else $error("smallest shift altered the product");

   a_shift_max_bound: assert property (
      expo == 3'h7 |-> scaled <= 14'sd29 && scaled >= -14'sd30)
      else $error("largest shift kept too much weight");

   a_disabled_zero_step: assert property (
      dis |-> scaled == 14'sh0000)
      else $error("disabled loop still scales an error");

   // Accumulator and limiters
   a_sum_in_window: assert property (
      lower <= upper |-> sum <= hi && sum >= lo)
      else $error("update escaped the limit window");

   a_crossed_lower_wins: assert property (
      lower > upper |-> sum == lo)
      else $error("crossed limits did not pin to lower");

   a_equal_limits_word: assert property (
      upper == lower |-> in_s.data == upper)
      else $error("equal limits did not set the word");

   a_disabled_keeps_word: assert property (
      dis && in_lim |-> in_s.data == top)
      else $error("disabled loop offered a new word");

   a_idle_keeps_acc: assert property (
      !accept |=> $stable(st.acc) && $stable(st.lin))
      else $error("gain moved without a sample");

   a_word_into_buffer: assert property (
      accept |=> gain_valid || !clk_en)
      else $error("accepted sample gave no gain word");

   a_step_any_bound: assert property (
      accept && in_lim && !cfg_wr |=>
      $signed({2'b00, st.acc}) - $signed({2'b00, $past(st.acc)}) <= 22'sd3825
      && $signed({2'b00, st.acc}) - $signed({2'b00, $past(st.acc)}) >= -22'sd3825)
      else $error("step beyond the largest loop gain");

   // Linear gain applied to the multipliers
   a_linear_floor: assert property (
      gain_linear >= 10'h040)
      else $error("linear gain below unity");

   a_linear_ceiling: assert property (
      gain_linear <= 10'h3f8)
      else $error("linear gain above top of range");

   a_linear_exp_only: assert property (
      top[5:0] == 6'h00 |-> gain_linear == (10'h040 << top[7:6]))
      else $error("exponent alone gave wrong linear gain");

   a_linear_mant_only: assert property (
      top[7:6] == 2'h0 |-> gain_linear == 10'h040 + {4'h0, top[5:0]})
      else $error("mantissa alone gave wrong linear gain");

   c_hit_upper: cover property (accept && !dis && sum == hi);
   c_hit_lower: cover property (accept && !dis && sum == lo);
   c_stall_full: cover property (mag_valid && !mag_ready && clk_en);
   c_disabled_update: cover property (accept && dis);
   c_equal_limits: cover property (accept && !dis && upper == lower);
endmodule
`default_nettype wire

// >>> bench/agcl_gain_sink.sv
`default_nettype none
module agcl_gain_sink (
   input wire logic clk, // System clock
   input wire logic resetn, // Async reset, active low
   input wire logic slow, // Random stalls while high
   output logic gain_ready // Word accepted
);
   timeunit 1ns;
   timeprecision 1ns;
   // Slow mode takes one word in four on average, so the buffer fills and refuses
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gain_ready <= 1'b0;
      end else begin
         gain_ready <= !slow || ($urandom % 4 == 0);
      end
   end
endmodule
`default_nettype wire

// >>> bench/agcl_loop_filter_tb.sv
`default_nettype none
module agcl_loop_filter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, resetn, clk_en, cfg_wr, mag_valid, mag_ready, gain_valid, gain_ready, slow;
   logic [31:0] cfg_wdata, cfg_rdata, sh;
   logic [7:0] mag_data, gain_status, gain_data;
   logic [9:0] gain_linear;
   logic [19:0] acc = 20'h00000;
   logic [7:0] q[$];
   logic pend = 1'b0;
   int fails = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [31:0] fix [4] = '{32'h0f00ff00, 32'h8f00ff00, 32'h0f004040, 32'h0fff1080};
   agcl_loop_filter u_agcl_loop_filter (.clk(clk), .resetn(resetn), .clk_en(clk_en), .cfg_wr(cfg_wr),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .gain_status(gain_status), .mag_valid(mag_valid),
      .mag_data(mag_data), .mag_ready(mag_ready), .gain_valid(gain_valid), .gain_ready(gain_ready),
      .gain_data(gain_data), .gain_linear(gain_linear));
   agcl_gain_sink u_agcl_gain_sink (.clk(clk), .resetn(resetn), .slow(slow), .gain_ready(gain_ready));
   function automatic logic [19:0] nxt(input logic [19:0] a, input logic [31:0] c, input logic [7:0] m);
      logic signed [8:0] err;
      logic signed [21:0] s;
      err = c[31] ? 9'sh000 : $signed({1'b0, m}) - $signed({1'b0, c[23:16]});
      s = $signed({2'b00, a}) + ((err * $signed({1'b0, c[27:24]})) >>> c[30:28]);
      if (s > $signed({2'b00, c[15:8], 12'hfff})) s = $signed({2'b00, c[15:8], 12'hfff});
      // Lower bound applied last, so it wins when the limits cross
      if (s < $signed({2'b00, c[7:0], 12'h000})) s = $signed({2'b00, c[7:0], 12'h000});
      return s[19:0];
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic send(input logic [7:0] m);
      logic r;
      mag_valid <= 1'b1;
      mag_data <= m;
      for (int w = 0; w < 200; w++) begin
         clk_en <= ($urandom % 8 != 0);
         @(negedge clk);
         r = mag_ready;
         @(posedge clk);
         if (r === 1'b1) break;
      end
      chk("mag_accepted", 32'h1, {31'h0, r});
   endtask
   task automatic run(input logic [31:0] c, input int t);
      mag_valid <= 1'b0;
      clk_en <= 1'b1;
      cfg_wr <= 1'b1;
      cfg_wdata <= c;
      sh = c;
      @(posedge clk);
      cfg_wr <= 1'b0;
      @(negedge clk);
      chk("cfg_rdata", c, cfg_rdata);
      @(posedge clk);
      slow <= t[0];
      for (int k = 0; k < 12; k++) send(t < 4 ? 8'hff : 8'($urandom));
      $display("test %0d done", t);
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         summarize();
      end
   end
   // Model steps at the negedge before the accepting edge, checks at the next negedge
   always @(negedge clk) begin
      if (resetn === 1'b1) begin
         if (pend) begin
            chk("gain_status", {24'h0, acc[19:12]}, {24'h0, gain_status});
            chk("gain_linear", ({4'h0, acc[17:12]} + 10'h040) << acc[19:18], {22'h0, gain_linear});
         end
         chk("mag_ready", {31'h0, clk_en && q.size() < 2}, {31'h0, mag_ready});
         chk("gain_valid", {31'h0, clk_en && q.size() > 0}, {31'h0, gain_valid});
         if (gain_valid === 1'b1 && gain_ready === 1'b1) chk("gain_data", {24'h0, q.pop_front()}, {24'h0, gain_data});
         pend = mag_valid === 1'b1 && mag_ready === 1'b1;
         if (pend) begin
            acc = nxt(acc, sh, mag_data);
            q.push_back(acc[19:12]);
         end
      end
   end
   initial begin
      logic [31:0] d;
      resetn = 1'b0;
      clk_en = 1'b1;
      cfg_wr = 1'b0;
      cfg_wdata = 32'h0;
      mag_valid = 1'b0;
      mag_data = 8'h00;
      slow = 1'b0;
      sh = agcl_pkg::CFG_RESET;
      void'($urandom(63651));
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      chk("cfg_rdata", agcl_pkg::CFG_RESET, cfg_rdata);
      chk("gain_status", 32'h0, {24'h0, gain_status});
      chk("gain_linear", {22'h0, agcl_pkg::LIN_RESET}, {22'h0, gain_linear});
      @(posedge clk);
      // Ramp, hold by disable, equal limits, crossed limits
      foreach (fix[i]) run(fix[i], i);
      for (int t = 4; t < 40; t++) begin
         d = $urandom;
         if (t % 4 == 0) d[7:0] = d[15:8];
         run(d, t);
      end
      // Let the buffer drain so every gain word is compared
      mag_valid <= 1'b0;
      slow <= 1'b0;
      clk_en <= 1'b1;
      repeat (12) @(posedge clk);
      chk("gain_drained", 32'h0, q.size());
      summarize();
   end
endmodule
`default_nettype wire
